/* design/sdram_bank_command_state.sv */
// Purpose: command decode and per-bank state legality, four-bank SDRAM
// Assumes: all command pins asynchronous to clk, two-stage synchronised
// Notes:   accept/illegal pulses report the outcome of each edge
`timescale 1ns/10ps
module sdram_bank_command_state #(
   parameter int BURST_LEN = sdram_cmd_pkg::BURST_LEN_DEF,
   parameter int ACTIVATE_TO_COLUMN_DELAY      = sdram_cmd_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC,
   parameter int PRECHARGE_PERIOD       = sdram_cmd_pkg::PRECHARGE_PERIOD_CYC,
   parameter int REFRESH_CYCLE_TIME      = sdram_cmd_pkg::REFRESH_CYCLE_TIME_CYC,
   parameter int MODE_SET_DELAY      = sdram_cmd_pkg::MODE_SET_DELAY_CYC,
   parameter int SELF_REFRESH_EXIT_TIME      = sdram_cmd_pkg::SELF_REFRESH_EXIT_TIME_CYC
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      cke,
   input  wire logic                      cs_n,
   input  wire logic                      ras_n,
   input  wire logic                      cas_n,
   input  wire logic                      we_n,
   input  wire logic                      auto_precharge_addr_bit,
   input  wire logic                      bank_select_hi,
   input  wire logic                      bank_select_lo,
   output sdram_cmd_pkg::bank_states_t    bank_states_q,
   output sdram_cmd_pkg::dev_state_t      dev_state_q,
   output sdram_cmd_pkg::cmd_t            cmd_q,
   output logic                           cmd_accept_q,
   output logic                           cmd_illegal_q,
   output logic                           all_idle_q
);
   localparam int W = sdram_cmd_pkg::CNT_W;
   localparam int NB = sdram_cmd_pkg::NUM_BANKS;
   localparam logic [W-1:0] ZERO    = '0;
   localparam logic [W-1:0] ONE     = W'(1);
   localparam logic [W-1:0] TRP_LD  = W'(PRECHARGE_PERIOD - 1);
   localparam logic [W-1:0] REFRESH_CYCLE_TIME_LD = W'(REFRESH_CYCLE_TIME - 1);
   localparam logic [W-1:0] MODE_SET_DELAY_LD = W'(MODE_SET_DELAY - 1);
   localparam logic [W-1:0] SELF_REFRESH_EXIT_TIME_LD = W'(SELF_REFRESH_EXIT_TIME - 1);

   if (BURST_LEN < 1 || BURST_LEN > sdram_cmd_pkg::CNT_MAX ||
       ACTIVATE_TO_COLUMN_DELAY < 1 || ACTIVATE_TO_COLUMN_DELAY > sdram_cmd_pkg::CNT_MAX ||
       PRECHARGE_PERIOD < 1 || PRECHARGE_PERIOD > sdram_cmd_pkg::CNT_MAX ||
       REFRESH_CYCLE_TIME < 1 || REFRESH_CYCLE_TIME > sdram_cmd_pkg::CNT_MAX ||
       MODE_SET_DELAY < 1 || MODE_SET_DELAY > sdram_cmd_pkg::CNT_MAX ||
       SELF_REFRESH_EXIT_TIME < 1 || SELF_REFRESH_EXIT_TIME > sdram_cmd_pkg::CNT_MAX) begin : g_bad_param
      $error("timing or burst parameter outside counter range");
   end

   // true when the bank may take this command addressed to itself
   function automatic logic own_ok(input sdram_cmd_pkg::bank_state_t s,
                                   input sdram_cmd_pkg::cmd_t c);
      logic ok;
      ok = 1'b0;
      case (c)
         sdram_cmd_pkg::CMD_ACTIVATE:
            ok = (s == sdram_cmd_pkg::BANK_IDLE);
         sdram_cmd_pkg::CMD_READ,
         sdram_cmd_pkg::CMD_WRITE:
            ok = (s == sdram_cmd_pkg::BANK_ACTIVE) ||
                 (s == sdram_cmd_pkg::BANK_READING) ||
                 (s == sdram_cmd_pkg::BANK_WRITING);
         sdram_cmd_pkg::CMD_PRECHARGE:
            ok = (s == sdram_cmd_pkg::BANK_IDLE) ||
                 (s == sdram_cmd_pkg::BANK_ACTIVE) ||
                 (s == sdram_cmd_pkg::BANK_READING) ||
                 (s == sdram_cmd_pkg::BANK_WRITING);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : own_ok

   // pin synchroniser; first stage feeds only the second
   sdram_cmd_pkg::cmd_pins_t pins_meta_q;
   sdram_cmd_pkg::cmd_pins_t pins_meta_d;
   sdram_cmd_pkg::cmd_pins_t pins_q;
   sdram_cmd_pkg::cmd_pins_t pins_d;
   logic                     cke_prev_q;
   logic                     cke_prev_d;

   always_comb begin
      pins_meta_d.cke                     = cke;
      pins_meta_d.cs_n                    = cs_n;
      pins_meta_d.ras_n                   = ras_n;
      pins_meta_d.cas_n                   = cas_n;
      pins_meta_d.we_n                    = we_n;
      pins_meta_d.auto_precharge_addr_bit = auto_precharge_addr_bit;
      pins_meta_d.bank_select_hi          = bank_select_hi;
      pins_meta_d.bank_select_lo          = bank_select_lo;
      pins_d                              = pins_meta_q;
      cke_prev_d                          = pins_q.cke;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pins_meta_q <= sdram_cmd_pkg::PINS_RESET;
         pins_q      <= sdram_cmd_pkg::PINS_RESET;
         cke_prev_q  <= 1'b0;
      end else begin
         pins_meta_q <= pins_meta_d;
         pins_q      <= pins_d;
         cke_prev_q  <= cke_prev_d;
      end
   end

   sdram_cmd_pkg::cmd_t cmd;

   sdram_cmd_decode u_decode (
      .pins (pins_q),
      .cmd  (cmd)
   );

   sdram_cmd_pkg::bank_state_t st [NB];
   sdram_cmd_pkg::action_t     act [NB];

   for (genvar b = 0; b < NB; b++) begin : g_bank
      sdram_bank_tracker #(
         .ACTIVATE_TO_COLUMN_DELAY  (ACTIVATE_TO_COLUMN_DELAY),
         .PRECHARGE_PERIOD   (PRECHARGE_PERIOD),
         .BURST (BURST_LEN)
      ) u_bank (
         .clk     (clk),
         .rst     (rst),
         .action  (act[b]),
         .state_q (st[b])
      );
   end

   // device-wide state and decision of this edge
   sdram_cmd_pkg::dev_state_t dev_state_d;
   logic [W-1:0]              dev_cnt_q;
   logic [W-1:0]              dev_cnt_d;
   logic [1:0]                last_bank_q;
   logic [1:0]                last_bank_d;
   logic [1:0]                sel;
   logic                      ap;
   logic                      live;
   logic                      busy_cmd;
   logic                      all_idle;
   logic                      all_pre_ok;
   logic                      accept;
   logic                      cmd_accept_d;
   logic                      cmd_illegal_d;

   always_comb begin
      sel        = {pins_q.bank_select_hi, pins_q.bank_select_lo};
      ap         = pins_q.auto_precharge_addr_bit;
      all_idle   = 1'b1;
      all_pre_ok = 1'b1;
      for (int i = 0; i < NB; i++) begin
         all_idle   = all_idle && (st[i] == sdram_cmd_pkg::BANK_IDLE);
         all_pre_ok = all_pre_ok && own_ok(st[i],
                                           sdram_cmd_pkg::CMD_PRECHARGE);
      end
      // both clock-enable samples high, normal operation
      live     = cke_prev_q && pins_q.cke &&
                 (dev_state_q == sdram_cmd_pkg::DEV_NORMAL);
      busy_cmd = (cmd != sdram_cmd_pkg::CMD_INHIBIT) &&
                 (cmd != sdram_cmd_pkg::CMD_NOP);
      accept   = 1'b0;
      if (live) begin
         case (cmd)
            sdram_cmd_pkg::CMD_REFRESH,
            sdram_cmd_pkg::CMD_MODE_LOAD:
               accept = all_idle;
            sdram_cmd_pkg::CMD_PRECHARGE:
               accept = ap ? all_pre_ok : own_ok(st[sel], cmd);
            sdram_cmd_pkg::CMD_TERMINATE:
               accept = (st[last_bank_q] == sdram_cmd_pkg::BANK_READING) ||
                        (st[last_bank_q] == sdram_cmd_pkg::BANK_WRITING);
            // other banks never block these
            sdram_cmd_pkg::CMD_ACTIVATE,
            sdram_cmd_pkg::CMD_READ,
            sdram_cmd_pkg::CMD_WRITE:
               accept = own_ok(st[sel], cmd);
            default: accept = 1'b0;
         endcase
      end
      // anything else that tries to execute is flagged
      cmd_accept_d  = accept;
      cmd_illegal_d = busy_cmd && !accept;

      for (int i = 0; i < NB; i++) begin
         act[i] = sdram_cmd_pkg::ACT_NONE;
         if (accept) begin
            case (cmd)
               sdram_cmd_pkg::CMD_ACTIVATE:
                  if (sel == 2'(i)) act[i] = sdram_cmd_pkg::ACT_OPEN;
               sdram_cmd_pkg::CMD_READ:
                  if (sel == 2'(i))
                     act[i] = ap ? sdram_cmd_pkg::ACT_READ_AP
                                 : sdram_cmd_pkg::ACT_READ;
                  else
                     act[i] = sdram_cmd_pkg::ACT_STOP;
               sdram_cmd_pkg::CMD_WRITE:
                  if (sel == 2'(i))
                     act[i] = ap ? sdram_cmd_pkg::ACT_WRITE_AP
                                 : sdram_cmd_pkg::ACT_WRITE;
                  else
                     act[i] = sdram_cmd_pkg::ACT_STOP;
               sdram_cmd_pkg::CMD_PRECHARGE:
                  if (ap) begin
                     act[i] = sdram_cmd_pkg::ACT_PRECHARGE;
                  end else if (sel == 2'(i) &&
                               st[i] != sdram_cmd_pkg::BANK_IDLE) begin
                     act[i] = sdram_cmd_pkg::ACT_PRECHARGE;
                  end
               sdram_cmd_pkg::CMD_TERMINATE:
                  if (last_bank_q == 2'(i))
                     act[i] = sdram_cmd_pkg::ACT_STOP;
               default: act[i] = sdram_cmd_pkg::ACT_NONE;
            endcase
         end
      end

      last_bank_d = last_bank_q;
      if (accept && (cmd == sdram_cmd_pkg::CMD_READ ||
                     cmd == sdram_cmd_pkg::CMD_WRITE)) begin
         last_bank_d = sel;
      end

      dev_state_d = dev_state_q;
      dev_cnt_d   = (dev_cnt_q == ZERO) ? ZERO : dev_cnt_q - ONE;
      case (dev_state_q)
         sdram_cmd_pkg::DEV_NORMAL: begin
            if (accept && cmd == sdram_cmd_pkg::CMD_REFRESH) begin
               dev_state_d = sdram_cmd_pkg::DEV_REFRESH;
               dev_cnt_d   = REFRESH_CYCLE_TIME_LD;
            end else if (accept && cmd == sdram_cmd_pkg::CMD_MODE_LOAD) begin
               dev_state_d = sdram_cmd_pkg::DEV_MODE;
               dev_cnt_d   = MODE_SET_DELAY_LD;
            end else if (accept && cmd == sdram_cmd_pkg::CMD_PRECHARGE &&
                         ap) begin
               dev_state_d = sdram_cmd_pkg::DEV_PALL;
               dev_cnt_d   = TRP_LD;
            end else if (cke_prev_q && !pins_q.cke && all_idle &&
                         cmd == sdram_cmd_pkg::CMD_REFRESH) begin
               dev_state_d = sdram_cmd_pkg::DEV_SELF;
            end
         end
         sdram_cmd_pkg::DEV_REFRESH,
         sdram_cmd_pkg::DEV_MODE,
         sdram_cmd_pkg::DEV_PALL,
         sdram_cmd_pkg::DEV_SELF_EXIT: begin
            if (dev_cnt_q == ZERO) begin
               dev_state_d = sdram_cmd_pkg::DEV_NORMAL;
            end
         end
         sdram_cmd_pkg::DEV_SELF: begin
            if (pins_q.cke) begin
               dev_state_d = sdram_cmd_pkg::DEV_SELF_EXIT;
               dev_cnt_d   = SELF_REFRESH_EXIT_TIME_LD;
            end
         end
         default: dev_state_d = sdram_cmd_pkg::DEV_NORMAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dev_state_q   <= sdram_cmd_pkg::DEV_NORMAL;
         dev_cnt_q     <= '0;
         last_bank_q   <= '0;
         cmd_q         <= sdram_cmd_pkg::CMD_INHIBIT;
         cmd_accept_q  <= 1'b0;
         cmd_illegal_q <= 1'b0;
      end else begin
         dev_state_q   <= dev_state_d;
         dev_cnt_q     <= dev_cnt_d;
         last_bank_q   <= last_bank_d;
         cmd_q         <= cmd;
         cmd_accept_q  <= cmd_accept_d;
         cmd_illegal_q <= cmd_illegal_d;
      end
   end

   // status copies so every output leaves a flip-flop of this module
   sdram_cmd_pkg::bank_states_t bank_states_d;
   logic                        all_idle_d;

   always_comb begin
      bank_states_d.st0 = st[0];
      bank_states_d.st1 = st[1];
      bank_states_d.st2 = st[2];
      bank_states_d.st3 = st[3];
      all_idle_d        = all_idle &&
                          (dev_state_q == sdram_cmd_pkg::DEV_NORMAL);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bank_states_q <= '0;
         all_idle_q    <= 1'b0;
      end else begin
         bank_states_q <= bank_states_d;
         all_idle_q    <= all_idle_d;
      end
   end
endmodule : sdram_bank_command_state

/* design/sdram_bank_tracker.sv */
// Purpose: state and delay counter of one bank
// Assumes: action already checked for legality by the caller
// Notes:   reset leaves the bank idle
`timescale 1ns/10ps
module sdram_bank_tracker #(
   parameter int ACTIVATE_TO_COLUMN_DELAY  = sdram_cmd_pkg::ACTIVATE_TO_COLUMN_DELAY_CYC,
   parameter int PRECHARGE_PERIOD   = sdram_cmd_pkg::PRECHARGE_PERIOD_CYC,
   parameter int BURST = sdram_cmd_pkg::BURST_LEN_DEF
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire sdram_cmd_pkg::action_t action,
   output sdram_cmd_pkg::bank_state_t  state_q
);
   localparam int W = sdram_cmd_pkg::CNT_W;
   localparam logic [W-1:0] ACTIVATE_TO_COLUMN_DELAY_LD  = W'(ACTIVATE_TO_COLUMN_DELAY - 1);
   localparam logic [W-1:0] TRP_LD   = W'(PRECHARGE_PERIOD - 1);
   localparam logic [W-1:0] BURST_LD = W'(BURST - 1);
   localparam logic [W-1:0] ZERO     = '0;
   localparam logic [W-1:0] ONE      = W'(1);

   sdram_cmd_pkg::bank_state_t state_d;
   logic [W-1:0]               cnt_q;
   logic [W-1:0]               cnt_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = (cnt_q == ZERO) ? ZERO : cnt_q - ONE;
      case (action)
         sdram_cmd_pkg::ACT_OPEN: begin
            state_d = sdram_cmd_pkg::BANK_ACTIVATING;
            cnt_d   = ACTIVATE_TO_COLUMN_DELAY_LD;
         end
         sdram_cmd_pkg::ACT_READ: begin
            state_d = sdram_cmd_pkg::BANK_READING;
            cnt_d   = BURST_LD;
         end
         sdram_cmd_pkg::ACT_WRITE: begin
            state_d = sdram_cmd_pkg::BANK_WRITING;
            cnt_d   = BURST_LD;
         end
         sdram_cmd_pkg::ACT_READ_AP: begin
            state_d = sdram_cmd_pkg::BANK_READ_AP;
            cnt_d   = BURST_LD;
         end
         sdram_cmd_pkg::ACT_WRITE_AP: begin
            state_d = sdram_cmd_pkg::BANK_WRITE_AP;
            cnt_d   = BURST_LD;
         end
         sdram_cmd_pkg::ACT_PRECHARGE: begin
            state_d = sdram_cmd_pkg::BANK_PRECHARGING;
            cnt_d   = TRP_LD;
         end
         sdram_cmd_pkg::ACT_STOP: begin
            case (state_q)
               sdram_cmd_pkg::BANK_READING,
               sdram_cmd_pkg::BANK_WRITING:
                  state_d = sdram_cmd_pkg::BANK_ACTIVE;
               sdram_cmd_pkg::BANK_READ_AP,
               sdram_cmd_pkg::BANK_WRITE_AP: begin
                  state_d = sdram_cmd_pkg::BANK_PRECHARGING;
                  cnt_d   = TRP_LD;
               end
               // a stop from another bank must not delay an expiry
               sdram_cmd_pkg::BANK_ACTIVATING:
                  if (cnt_q == ZERO)
                     state_d = sdram_cmd_pkg::BANK_ACTIVE;
               sdram_cmd_pkg::BANK_PRECHARGING:
                  if (cnt_q == ZERO)
                     state_d = sdram_cmd_pkg::BANK_IDLE;
               default: state_d = state_q;
            endcase
         end
         default: begin
            if (cnt_q == ZERO) begin
               case (state_q)
                  sdram_cmd_pkg::BANK_ACTIVATING,
                  sdram_cmd_pkg::BANK_READING,
                  sdram_cmd_pkg::BANK_WRITING:
                     state_d = sdram_cmd_pkg::BANK_ACTIVE;
                  sdram_cmd_pkg::BANK_READ_AP,
                  sdram_cmd_pkg::BANK_WRITE_AP: begin
                     state_d = sdram_cmd_pkg::BANK_PRECHARGING;
                     cnt_d   = TRP_LD;
                  end
                  sdram_cmd_pkg::BANK_PRECHARGING:
                     state_d = sdram_cmd_pkg::BANK_IDLE;
                  default: state_d = state_q;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= sdram_cmd_pkg::BANK_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end
endmodule : sdram_bank_tracker

/* design/sdram_cmd_decode.sv */
// Purpose: turns the registered strobe levels into one command code
// Assumes: pins already synchronised to clk
// Notes:   purely combinational
`timescale 1ns/10ps
module sdram_cmd_decode (
   input  wire sdram_cmd_pkg::cmd_pins_t pins,
   output sdram_cmd_pkg::cmd_t           cmd
);
   always_comb begin
      if (pins.cs_n) begin
         cmd = sdram_cmd_pkg::CMD_INHIBIT;
      end else begin
         case ({pins.ras_n, pins.cas_n, pins.we_n})
            3'h7:    cmd = sdram_cmd_pkg::CMD_NOP;
            3'h3:    cmd = sdram_cmd_pkg::CMD_ACTIVATE;
            3'h5:    cmd = sdram_cmd_pkg::CMD_READ;
            3'h4:    cmd = sdram_cmd_pkg::CMD_WRITE;
            3'h2:    cmd = sdram_cmd_pkg::CMD_PRECHARGE;
            3'h6:    cmd = sdram_cmd_pkg::CMD_TERMINATE;
            3'h1:    cmd = sdram_cmd_pkg::CMD_REFRESH;
            3'h0:    cmd = sdram_cmd_pkg::CMD_MODE_LOAD;
            default: cmd = sdram_cmd_pkg::CMD_NOP;
         endcase
      end
   end
endmodule : sdram_cmd_decode

/* design/sdram_cmd_pkg.sv */
// Purpose: shared types and timing constants for the bank command tracker
// Assumes: 100 MHz system clock, four banks
// Notes:   times are kept in ps and turned into cycle counts here, except the mode set delay, given in cycles
package sdram_cmd_pkg;

   localparam int CLK_PERIOD_PS = 10000;

   // least times, rounded up to whole cycles
   localparam int PRECHARGE_PERIOD_PS        = 20000;
   localparam int ACTIVATE_TO_COLUMN_DELAY_PS = 20000;
   localparam int REFRESH_CYCLE_TIME_PS      = 66000;
   localparam int SELF_REFRESH_EXIT_TIME_PS  = 75000;
   localparam int MODE_SET_DELAY_CYC         = 2;

   localparam int PRECHARGE_PERIOD_CYC =
      (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACTIVATE_TO_COLUMN_DELAY_CYC =
      (ACTIVATE_TO_COLUMN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFRESH_CYCLE_TIME_CYC =
      (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SELF_REFRESH_EXIT_TIME_CYC =
      (SELF_REFRESH_EXIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   localparam int BURST_LEN_DEF = 4;
   localparam int NUM_BANKS     = 4;
   localparam int CNT_W         = 4;
   localparam int CNT_MAX       = (1 << CNT_W) - 1;

   typedef enum logic [3:0] {
      CMD_INHIBIT   = 4'h0,
      CMD_NOP       = 4'h1,
      CMD_ACTIVATE  = 4'h2,
      CMD_READ      = 4'h3,
      CMD_WRITE     = 4'h4,
      CMD_PRECHARGE = 4'h5,
      CMD_TERMINATE = 4'h6,
      CMD_REFRESH   = 4'h7,
      CMD_MODE_LOAD = 4'h8
   } cmd_t;

   typedef enum logic [2:0] {
      BANK_IDLE        = 3'h0,
      BANK_ACTIVATING  = 3'h1,
      BANK_ACTIVE      = 3'h2,
      BANK_READING     = 3'h3,
      BANK_WRITING     = 3'h4,
      BANK_READ_AP     = 3'h5,
      BANK_WRITE_AP    = 3'h6,
      BANK_PRECHARGING = 3'h7
   } bank_state_t;

   typedef enum logic [2:0] {
      ACT_NONE      = 3'h0,
      ACT_OPEN      = 3'h1,
      ACT_READ      = 3'h2,
      ACT_WRITE     = 3'h3,
      ACT_READ_AP   = 3'h4,
      ACT_WRITE_AP  = 3'h5,
      ACT_PRECHARGE = 3'h6,
      ACT_STOP      = 3'h7
   } action_t;

   typedef enum logic [2:0] {
      DEV_NORMAL    = 3'h0,
      DEV_REFRESH   = 3'h1,
      DEV_MODE      = 3'h2,
      DEV_PALL      = 3'h3,
      DEV_SELF      = 3'h4,
      DEV_SELF_EXIT = 3'h5
   } dev_state_t;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic auto_precharge_addr_bit;
      logic bank_select_hi;
      logic bank_select_lo;
   } cmd_pins_t;

   localparam cmd_pins_t PINS_RESET = 8'h40;

   typedef struct packed {
      bank_state_t st3;
      bank_state_t st2;
      bank_state_t st1;
      bank_state_t st0;
   } bank_states_t;

endpackage : sdram_cmd_pkg

/* tb/sdram_cmd_chk.sv */
// Purpose: port-level timing checks on the bank command tracker
// Assumes: default timing parameters of the package
// Notes:   bound to the top module below
`timescale 1ns/10ps
module sdram_cmd_chk (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        cs_n,
   input wire sdram_cmd_pkg::bank_states_t bank_states_q,
   input wire sdram_cmd_pkg::dev_state_t   dev_state_q,
   input wire sdram_cmd_pkg::cmd_t         cmd_q,
   input wire logic                        cmd_accept_q,
   input wire logic                        cmd_illegal_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_pulse_excl: assert property (
      !(cmd_accept_q && cmd_illegal_q))
      else $error("accept and refuse together");
   a_nop_quiet: assert property (
      cmd_q inside {sdram_cmd_pkg::CMD_INHIBIT, sdram_cmd_pkg::CMD_NOP}
      |-> !cmd_accept_q && !cmd_illegal_q)
      else $error("pulse on idle command");
   a_cs_inhibit: assert property (
      $past(cs_n, 3) |-> cmd_q == sdram_cmd_pkg::CMD_INHIBIT)
      else $error("deselect not inhibit");
   a_act_len: assert property (
      $rose(bank_states_q.st1 == sdram_cmd_pkg::BANK_ACTIVATING) |->
      ##2 bank_states_q.st1 == sdram_cmd_pkg::BANK_ACTIVE)
      else $error("activate delay wrong");
   a_ref_len: assert property (
      $rose(dev_state_q == sdram_cmd_pkg::DEV_REFRESH) |->
      (dev_state_q == sdram_cmd_pkg::DEV_REFRESH)[*7] ##1
      dev_state_q == sdram_cmd_pkg::DEV_NORMAL)
      else $error("refresh length");
   a_mode_len: assert property (
      $rose(dev_state_q == sdram_cmd_pkg::DEV_MODE) |->
      (dev_state_q == sdram_cmd_pkg::DEV_MODE)[*2] ##1
      dev_state_q == sdram_cmd_pkg::DEV_NORMAL)
      else $error("mode length");
   a_pall_len: assert property (
      $rose(dev_state_q == sdram_cmd_pkg::DEV_PALL) |->
      (dev_state_q == sdram_cmd_pkg::DEV_PALL)[*2] ##1
      dev_state_q == sdram_cmd_pkg::DEV_NORMAL ##[0:2]
      bank_states_q == 12'h000)
      else $error("precharge all length");
   a_ap_read: assert property (
      $rose(bank_states_q.st0 == sdram_cmd_pkg::BANK_READ_AP) |->
      (bank_states_q.st0 == sdram_cmd_pkg::BANK_READ_AP)[*4] ##1
      (bank_states_q.st0 == sdram_cmd_pkg::BANK_PRECHARGING)[*2] ##1
      bank_states_q.st0 == sdram_cmd_pkg::BANK_IDLE)
      else $error("ap read");
endmodule : sdram_cmd_chk
bind sdram_bank_command_state sdram_cmd_chk sdram_cmd_chk_inst (.clk(clk),
   .rst(rst), .cs_n(cs_n), .bank_states_q(bank_states_q),
   .dev_state_q(dev_state_q), .cmd_q(cmd_q), .cmd_accept_q(cmd_accept_q),
   .cmd_illegal_q(cmd_illegal_q));

/* tb/sdram_ctrl_model.sv */
// Purpose: far-side controller, turns a command code into pin levels
// Assumes: clock enable and sequencing kept by the caller
// Notes:   bank and address bit follow the inputs only while selected, inverted when deselected
`timescale 1ns/10ps
module sdram_ctrl_model (
   input  wire logic                 cke,
   input  wire sdram_cmd_pkg::cmd_t  op,
   input  wire logic                 ap,
   input  wire logic [1:0]           bank,
   output sdram_cmd_pkg::cmd_pins_t  pins
);
   logic [3:0] strb;
   always_comb begin
      case (op)
         sdram_cmd_pkg::CMD_NOP:       strb = 4'h7;
         sdram_cmd_pkg::CMD_ACTIVATE:  strb = 4'h3;
         sdram_cmd_pkg::CMD_READ:      strb = 4'h5;
         sdram_cmd_pkg::CMD_WRITE:     strb = 4'h4;
         sdram_cmd_pkg::CMD_PRECHARGE: strb = 4'h2;
         sdram_cmd_pkg::CMD_TERMINATE: strb = 4'h6;
         sdram_cmd_pkg::CMD_REFRESH:   strb = 4'h1;
         sdram_cmd_pkg::CMD_MODE_LOAD: strb = 4'h0;
         default:                      strb = 4'hf;
      endcase
      // deselected: address lines driven as the inverse of the ap and bank inputs
      if (strb == 4'hf) pins = {cke, strb, ~ap, ~bank};
      else pins = {cke, strb, ap, bank};
   end
endmodule : sdram_ctrl_model

/* tb/tb_top.sv */
// Purpose: directed scenarios for the bank command tracker
// Assumes: default timing parameters, pins driven 1 ns after clk rises
// Notes:   results read three edges after a command is presented
`timescale 1ns/10ps
module tb_top;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   sdram_cmd_pkg::cmd_t         op = sdram_cmd_pkg::CMD_INHIBIT;
   logic                        ap = 1'b0;
   logic [1:0]                  bank = 2'h0;
   sdram_cmd_pkg::cmd_pins_t    pins;
   sdram_cmd_pkg::bank_states_t bst;
   sdram_cmd_pkg::dev_state_t   dst;
   sdram_cmd_pkg::cmd_t         cmd_q;
   logic                        acc, ill, idl;
   logic                        cke = 1'b1;
   int                          failures = 0;
   int                          n_checks = 0;
   always #5 clk = ~clk;
   sdram_ctrl_model sdram_ctrl_model_inst (.cke(cke), .op(op), .ap(ap),
      .bank(bank), .pins(pins));
   sdram_bank_command_state sdram_bank_command_state_inst (.clk(clk),
      .rst(rst), .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
      .cas_n(pins.cas_n), .we_n(pins.we_n),
      .auto_precharge_addr_bit(pins.auto_precharge_addr_bit),
      .bank_select_hi(pins.bank_select_hi),
      .bank_select_lo(pins.bank_select_lo), .bank_states_q(bst),
      .dev_state_q(dst), .cmd_q(cmd_q), .cmd_accept_q(acc),
      .cmd_illegal_q(ill), .all_idle_q(idl));
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: exp %h got %h", $time, exp, got);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   // ex is {accept, refuse}
   task automatic send(input sdram_cmd_pkg::cmd_t c, input logic a,
                       input logic [1:0] b, input logic [1:0] ex);
      op = c;
      ap = a;
      bank = b;
      wt(1);
      op = sdram_cmd_pkg::CMD_NOP;
      wt(2);
      chk({12'h0, c}, {12'h0, cmd_q});
      chk({14'h0, ex}, {14'h0, acc, ill});
   endtask : send
   task automatic s_row_cycle();
      send(sdram_cmd_pkg::CMD_INHIBIT, 1'b0, 2'h0, 2'b00);
      send(sdram_cmd_pkg::CMD_NOP, 1'b0, 2'h0, 2'b00);
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h0, 2'b10);
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h0, 2'b01);
      wt(2);
      chk(16'h0002, {4'h0, bst});
      send(sdram_cmd_pkg::CMD_READ, 1'b1, 2'h0, 2'b10);
      wt(1);
      chk(16'h0005, {4'h0, bst});
      wt(8);
      send(sdram_cmd_pkg::CMD_PRECHARGE, 1'b0, 2'h3, 2'b10);
      wt(1);
      chk(16'h0000, {4'h0, bst});
      chk(16'h0001, {15'h0, idl});
   endtask : s_row_cycle
   task automatic s_terminate();
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h2, 2'b10);
      wt(3);
      send(sdram_cmd_pkg::CMD_WRITE, 1'b0, 2'h2, 2'b10);
      send(sdram_cmd_pkg::CMD_TERMINATE, 1'b0, 2'h0, 2'b10);
      wt(1);
      chk(16'h0080, {4'h0, bst});
      send(sdram_cmd_pkg::CMD_TERMINATE, 1'b0, 2'h0, 2'b01);
      send(sdram_cmd_pkg::CMD_PRECHARGE, 1'b1, 2'h0, 2'b10);
      wt(4);
      chk(16'h0000, {4'h0, bst});
   endtask : s_terminate
   task automatic s_refresh();
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h1, 2'b10);
      send(sdram_cmd_pkg::CMD_REFRESH, 1'b0, 2'h0, 2'b01);
      send(sdram_cmd_pkg::CMD_PRECHARGE, 1'b0, 2'h1, 2'b10);
      wt(3);
      send(sdram_cmd_pkg::CMD_REFRESH, 1'b0, 2'h0, 2'b10);
      chk({13'h0, sdram_cmd_pkg::DEV_REFRESH}, {13'h0, dst});
      send(sdram_cmd_pkg::CMD_MODE_LOAD, 1'b0, 2'h0, 2'b01);
      chk(16'h0000, {15'h0, idl});
      wt(8);
      send(sdram_cmd_pkg::CMD_MODE_LOAD, 1'b0, 2'h0, 2'b10);
      chk({13'h0, sdram_cmd_pkg::DEV_MODE}, {13'h0, dst});
   endtask : s_refresh
   task automatic s_self();
      cke = 1'b0;
      send(sdram_cmd_pkg::CMD_REFRESH, 1'b0, 2'h0, 2'b01);
      chk({13'h0, sdram_cmd_pkg::DEV_SELF}, {13'h0, dst});
      cke = 1'b1;
      wt(3);
      chk({13'h0, sdram_cmd_pkg::DEV_SELF_EXIT}, {13'h0, dst});
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h0, 2'b01);
      wt(8);
      send(sdram_cmd_pkg::CMD_ACTIVATE, 1'b0, 2'h0, 2'b10);
   endtask : s_self
   task automatic complete_run();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      #20000;
      failures++;
      complete_run();
   end
   initial begin
      wt(20);
      rst = 1'b0;
      wt(4);
      s_row_cycle();
      s_terminate();
      s_refresh();
      s_self();
      complete_run();
   end
endmodule : tb_top
